/* File: logic/input_capture_control.v */
`timescale 1ns/100ps
`default_nettype none
`include "capture_ctrl_map.vh"
module input_capture_control #(
  parameter FILT_CYCLES = `FILTER_CYCLES
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // ahb-lite slave
  input wire hsel,
  input wire [9:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  // capture pins and timer
  input wire [2:0] capturePin,
  input wire timerOverflow,
  // events
  output reg [2:0] captureEvent,
  output reg counterReload
);
  // ****************
  // pin and timer synchronisers
  // ****************
  reg [2:0] pinMeta_ff;
  reg [2:0] pinSync_ff;
  always @(posedge ref_clk) begin
    if (rst) begin
      pinMeta_ff <= 3'h0;
      pinSync_ff <= 3'h0;
    end else begin
      pinMeta_ff <= capturePin;
      pinSync_ff <= pinMeta_ff;
    end
  end

  reg timerMeta_ff;
  reg timerSync_ff;
  always @(posedge ref_clk) begin
    if (rst) begin
      timerMeta_ff <= 1'b0;
      timerSync_ff <= 1'b0;
    end else begin
      timerMeta_ff <= timerOverflow;
      timerSync_ff <= timerMeta_ff;
    end
  end

  // ****************
  // bus address phase
  // ****************
  reg [7:0] edgeReload_ff;
  reg [7:0] filterFlag_ff;
  reg wrPend_ff;
  reg [9:0] wrAddr_ff;
  wire addrPhase;
  wire rdAccept;
  wire wrAccept;

  assign addrPhase = hsel & htrans[1] & hready;
  assign rdAccept = addrPhase & ~hwrite;
  assign wrAccept = addrPhase & hwrite;

  // address held for the write data phase
  always @(posedge ref_clk) begin
    if (rst) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 10'h000;
    end else begin
      wrPend_ff <= wrAccept;
      if (wrAccept) begin
        wrAddr_ff <= haddr;
      end
    end
  end

  // ****************
  // register write
  // ****************
  wire wrEdgeReload;
  wire wrFilterFlag;
  reg [7:0] nxt_edgeReload;
  reg [7:0] nxt_filterFlag;

  assign wrEdgeReload = wrPend_ff & (wrAddr_ff == `EDGE_RELOAD_ADDR);
  assign wrFilterFlag = wrPend_ff & (wrAddr_ff == `FILTER_FLAG_ADDR);

  // data phase write; flag bits are not kept
  always @* begin
    nxt_edgeReload = edgeReload_ff;
    nxt_filterFlag = filterFlag_ff;
    if (wrEdgeReload) begin
      nxt_edgeReload = hwdata[7:0];
    end else if (wrFilterFlag) begin
      nxt_filterFlag = {2'h0, hwdata[5:3], 3'h0};
    end
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      edgeReload_ff <= `EDGE_RELOAD_RST;
      filterFlag_ff <= `FILTER_FLAG_RST;
    end else begin
      edgeReload_ff <= nxt_edgeReload;
      filterFlag_ff <= nxt_filterFlag;
    end
  end

  // ****************
  // register read
  // ****************
  reg [31:0] nxt_hrdata;

  // read sees a write still in its data phase
  always @* begin
    nxt_hrdata = 32'h00000000;
    if (haddr == `EDGE_RELOAD_ADDR) begin
      nxt_hrdata = {24'h000000, nxt_edgeReload};
    end else if (haddr == `FILTER_FLAG_ADDR) begin
      nxt_hrdata = {24'h000000, nxt_filterFlag};
    end
  end

  // ****************
  // bus response
  // ****************
  always @(posedge ref_clk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (rdAccept) begin
        hrdata <= nxt_hrdata;
      end
    end
  end

  // ****************
  // field extraction
  // ****************
  wire [1:0] chan0EdgeSelect;
  wire [1:0] chan1EdgeSelect;
  wire [1:0] chan2EdgeSelect;
  wire [1:0] reloadSourceSelect;
  wire chan0FilterEnable;
  wire chan1FilterEnable;
  wire chan2FilterEnable;
  wire [5:0] edgeSel;
  wire [2:0] filtEn;

  assign chan0EdgeSelect = edgeReload_ff[`CH0_EDGE_HI:`CH0_EDGE_LO];
  assign chan1EdgeSelect = edgeReload_ff[`CH1_EDGE_HI:`CH1_EDGE_LO];
  assign chan2EdgeSelect = edgeReload_ff[`CH2_EDGE_HI:`CH2_EDGE_LO];
  assign reloadSourceSelect = edgeReload_ff[`RELOAD_HI:`RELOAD_LO];
  assign chan0FilterEnable = filterFlag_ff[`CH0_FILT_BIT];
  assign chan1FilterEnable = filterFlag_ff[`CH1_FILT_BIT];
  assign chan2FilterEnable = filterFlag_ff[`CH2_FILT_BIT];
  assign edgeSel = {chan2EdgeSelect, chan1EdgeSelect, chan0EdgeSelect};
  assign filtEn = {chan2FilterEnable, chan1FilterEnable, chan0FilterEnable};

  // ****************
  // capture channels
  // ****************
  wire [2:0] chanEvent;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : chan
      capture_channel #(
        .FILT_CYCLES(FILT_CYCLES)
      ) u_chan (
        .ref_clk(ref_clk),
        .rst(rst),
        .edgeSelect(edgeSel[2*gi+1:2*gi]),
        .filterEnable(filtEn[gi]),
        .pinLevel(pinSync_ff[gi]),
        .capEvent_ff(chanEvent[gi])
      );
    end
  endgenerate

  // ****************
  // reload select
  // ****************
  reg nxt_reload;
  always @* begin
    case (reloadSourceSelect)
      `RELOAD_TIMER: nxt_reload = timerSync_ff;
      `RELOAD_CH0: nxt_reload = chanEvent[0];
      `RELOAD_CH1: nxt_reload = chanEvent[1];
      default: nxt_reload = chanEvent[2];
    endcase
  end

  // ****************
  // event outputs
  // ****************
  always @(posedge ref_clk) begin
    if (rst) begin
      captureEvent <= 3'h0;
      counterReload <= 1'b0;
    end else begin
      captureEvent <= chanEvent;
      counterReload <= nxt_reload;
    end
  end
endmodule
`default_nettype wire

/* File: logic/capture_ctrl_map.vh */
`ifndef CAPTURE_CTRL_MAP_VH
`define CAPTURE_CTRL_MAP_VH
// register indices as printed; byte address is index times four
`define EDGE_RELOAD_IDX 8'hA3
`define FILTER_FLAG_IDX 8'hA4
`define EDGE_RELOAD_ADDR 10'h28C
`define FILTER_FLAG_ADDR 10'h290
// field positions in the edge/reload register
`define CH2_EDGE_HI 7
`define CH2_EDGE_LO 6
`define CH1_EDGE_HI 5
`define CH1_EDGE_LO 4
`define CH0_EDGE_HI 3
`define CH0_EDGE_LO 2
`define RELOAD_HI 1
`define RELOAD_LO 0
// field positions in the filter/flag register
`define CH2_FILT_BIT 5
`define CH1_FILT_BIT 4
`define CH0_FILT_BIT 3
// reset values
`define EDGE_RELOAD_RST 8'h00
`define FILTER_FLAG_RST 8'h00
// edge codes
`define EDGE_RISE 2'h0
`define EDGE_FALL 2'h1
`define EDGE_BOTH 2'h2
// reload sources
`define RELOAD_TIMER 2'h0
`define RELOAD_CH0 2'h1
`define RELOAD_CH1 2'h2
`define RELOAD_CH2 2'h3
// noise filter settle time in ns, and the count at 100 MHz
`define FILTER_TIME_NS 40
`define CLK_PERIOD_NS 10
`define FILTER_CYCLES ((`FILTER_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

/* File: logic/capture_channel.v */
`timescale 1ns/100ps
`default_nettype none
`include "capture_ctrl_map.vh"
module capture_channel #(
  parameter FILT_CYCLES = `FILTER_CYCLES
) (
  // clock and reset
  input wire ref_clk,
  input wire rst,
  // control
  input wire [1:0] edgeSelect,
  input wire filterEnable,
  // synchronised pin level
  input wire pinLevel,
  // capture event
  output reg capEvent_ff
);
  // ****************
  // noise filter
  // ****************
  reg [3:0] filtCnt_ff;
  reg filtLevel_ff;
  reg prevLevel_ff;
  wire useLevel;
  wire rise;
  wire fall;
  reg nxt_capEvent;

  always @(posedge ref_clk) begin
    if (rst) begin
      filtCnt_ff <= 4'h0;
      filtLevel_ff <= 1'b0;
    end else if (pinLevel == filtLevel_ff) begin
      filtCnt_ff <= 4'h0;
    end else if (filtCnt_ff >= FILT_CYCLES - 1) begin
      filtCnt_ff <= 4'h0;
      filtLevel_ff <= pinLevel;
    end else begin
      filtCnt_ff <= filtCnt_ff + 4'h1;
    end
  end

  assign useLevel = filterEnable ? filtLevel_ff : pinLevel;

  // ****************
  // edge detection
  // ****************
  assign rise = useLevel & ~prevLevel_ff;
  assign fall = ~useLevel & prevLevel_ff;

  always @* begin
    case (edgeSelect)
      `EDGE_RISE: nxt_capEvent = rise;
      `EDGE_FALL: nxt_capEvent = fall;
      `EDGE_BOTH: nxt_capEvent = rise | fall;
      default: nxt_capEvent = 1'b0;
    endcase
  end

  always @(posedge ref_clk) begin
    if (rst) begin
      prevLevel_ff <= 1'b0;
      capEvent_ff <= 1'b0;
    end else begin
      prevLevel_ff <= useLevel;
      capEvent_ff <= nxt_capEvent;
    end
  end
endmodule
`default_nettype wire

/* File: test/input_capture_control_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module icc_check (
  // clock, reset, bus
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [9:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  // capture side
  input wire logic [2:0] capturePin,
  input wire logic timerOverflow,
  input wire logic [2:0] captureEvent,
  input wire logic counterReload
);
  logic [7:0] cfg_ff;
  logic flt_ff;
  logic [9:0] wa_ff;
  wire logic [3:0] evSel = {captureEvent, 1'b0};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ****
  // register shadow
  // ****
  always @(posedge ref_clk) begin
    wa_ff <= (hsel && htrans[1] && hwrite) ? haddr : 10'h000;
    cfg_ff <= rst ? 8'h00 : (wa_ff == 10'h28C) ? hwdata[7:0] : cfg_ff;
    flt_ff <= rst ? 1'b0 : (wa_ff == 10'h290) ? hwdata[5] : flt_ff;
  end
  a_rise_ch2: assert property (cfg_ff[7:6] == 2'h0 && !flt_ff && $rose(capturePin[2])
    |-> ##[3:4] captureEvent[2]) else $error("rise lost");
  a_both_ch1: assert property (cfg_ff[5:4] == 2'h2 && $changed(capturePin[1])
    |-> ##[3:4] captureEvent[1]) else $error("edge lost");
  a_timer_reload: assert property (cfg_ff[1:0] == 2'h0 && timerOverflow
    |-> ##[2:3] counterReload) else $error("timer reload lost");
  a_event_reload: assert property (cfg_ff[1:0] != 2'h0
    |-> counterReload == evSel[cfg_ff[1:0]]) else $error("wrong reload");
  a_filter_glitch: assert property (flt_ff && $rose(capturePin[2]) ##1 capturePin[2]
    ##1 !capturePin[2] |-> !captureEvent[2] [*8]) else $error("glitch passed");
  cover property (counterReload && cfg_ff[1:0] == 2'h0);
  cover property (captureEvent[1] && cfg_ff[5:4] == 2'h2);
  cover property (captureEvent[2] && flt_ff);
endmodule
`default_nettype wire

/* File: test/pin_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_model (
  // clock, levels asked for
  input wire logic ref_clk,
  input wire logic [2:0] level,
  // pins
  output logic [2:0] capturePin
);
  always @(posedge ref_clk) capturePin <= #3 level;
endmodule
`default_nettype wire

/* File: test/input_capture_control_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module input_capture_control_tb;
  logic ref_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, timerOverflow = 1'b0;
  logic [9:0] haddr = 10'h000;
  logic [1:0] htrans = 2'h0;
  logic [31:0] hwdata = 32'h0, r;
  logic [2:0] level = 3'h0;
  logic [7:0] ev [4] = '{default: 8'h00};
  logic [7:0] ne [4] = '{8'h01, 8'h01, 8'h02, 8'h00};
  int failCount = 0, nTests = 0;
  wire logic [31:0] hrdata;
  wire logic hreadyout, counterReload, hresp;
  wire logic [2:0] capturePin, captureEvent;
  wire logic [3:0] evs = {counterReload, captureEvent};
  input_capture_control uut (
    .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .capturePin(capturePin),
    .timerOverflow(timerOverflow), .captureEvent(captureEvent), .counterReload(counterReload)
  );
  pin_model pins (.ref_clk(ref_clk), .level(level), .capturePin(capturePin));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) if (evs[i] === 1'b1) ev[i] <= ev[i] + 8'h01;
  end
  task automatic chk(input logic [31:0] g, e);
    nTests++;
    if (g !== e) begin
      failCount++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, w, a};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  // ****
  // pulse a pin or the timer, count events and reloads
  // ****
  task automatic run(input int ch, w, input logic [7:0] e);
    logic [7:0] e0, r0;
    {e0, r0} = {ev[ch], ev[3]};
    {timerOverflow, level} <= 4'(1 << ch);
    repeat (w) @(posedge ref_clk);
    {timerOverflow, level} <= 4'h0;
    repeat (20) @(posedge ref_clk);
    chk({ev[ch] - e0, ev[3] - r0}, {e, e});
  endtask
  task automatic stopTest;
    $display("checks %0d mismatches %0d", nTests, failCount);
    if (failCount == 0 && nTests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    failCount++;
    $display("[FAIL] %0t timeout", $time);
    stopTest;
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    xfer(1'b0, 10'h28C, 32'h0);
    chk(r, 32'h0);
    xfer(1'b0, 10'h3FC, 32'h0);
    chk(r, 32'h0);
    run(3, 1, 8'h01);
    for (int i = 0; i < 12; i++) begin
      xfer(1'b1, 10'h28C, 32'((i % 4) << (i / 4 * 2 + 2) | (i / 4 + 1)));
      run(i / 4, 6, ne[i % 4]);
    end
    run(3, 1, 8'h00);
    xfer(1'b1, 10'h290, 32'hFF);
    xfer(1'b0, 10'h290, 32'h0);
    chk(r, 32'h38);
    chk({31'h0, hresp}, 32'h0);
    xfer(1'b1, 10'h290, 32'h20);
    xfer(1'b1, 10'h28C, 32'h03);
    xfer(1'b0, 10'h28C, 32'h0);
    chk(r, 32'h03);
    run(2, 2, 8'h00);
    run(2, 8, 8'h01);
    stopTest;
  end
endmodule
bind input_capture_control icc_check checks (
  .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .capturePin(capturePin),
  .timerOverflow(timerOverflow), .captureEvent(captureEvent), .counterReload(counterReload)
);
`default_nettype wire
